// *** pkg/t1m_defs.svh ***
/*
 * Constants of the T1 line test and alarm status block.
 * Assumes a 40 MHz system clock; included by the package and the maintenance module.
 */
`ifndef T1M_DEFS_SVH
`define T1M_DEFS_SVH
// Timing figures in their own units.
`define T1M_CLK_HZ 40000000
`define T1M_TENTH_MS 100
`define T1M_CODE_S 10
`define T1M_RED_MS 2500
`define T1M_INTV_MIN 15
// Sizes.
`define T1M_NINTV 96
`define T1M_NSLOT 24
`define T1M_NPORT 4
`define T1M_CW 10
`define T1M_TW 17
// Send code values.
`define T1M_SC_NONE 4'h1
`define T1M_SC_UP 4'h2
`define T1M_SC_DN 4'h4
`define T1M_SC_QRSS 4'h5
`define T1M_SC_OTH 4'h8
// Loopback state values.
`define T1M_LB_NONE 2'h1
`define T1M_LB_PAY 2'h2
`define T1M_LB_LINE 2'h3
// Alarm status bit positions.
`define T1M_AL_NONE 0
`define T1M_AL_YEL 1
`define T1M_AL_AIS 3
`define T1M_AL_LOF 5
`define T1M_AL_LOS 6
`define T1M_AL_LBK 7
`define T1M_AL_OTH 12
`define T1M_AL_W 13
// Signaling, clock source and data link values.
`define T1M_SM_NONE 2'h1
`define T1M_SM_RBS 2'h2
`define T1M_CS_LOOP 2'h1
`define T1M_CS_LOCAL 2'h2
`define T1M_CS_THRU 2'h3
`define T1M_FDL_PRM 4'h2
`define T1M_FDL_CARR 4'h4
`define T1M_FDL_NONE 4'h8
`endif

// *** pkg/t1m_pkg.sv ***
/*
 * Types of the T1 line test and alarm status block.
 * Assumes the constants header sits beside it.
 */
`include "t1m_defs.svh"
package t1m_pkg;
    // Outgoing pattern state, Gray coded along the usual path.
    typedef enum logic [2:0] {
        T1M_TX_IDLE = 3'h0,
        T1M_TX_UP = 3'h1,
        T1M_TX_DN = 3'h3,
        T1M_TX_QRSS = 3'h2,
        T1M_TX_OTH = 3'h6
    } t1m_tx_t;
    // Line conditions from a framer, on the system clock.
    typedef struct packed {
        logic oof;
        logic los;
        logic yellow;
        logic ais;
        logic excessive_error_rate;
        logic pay_loop;
        logic line_loop;
        logic loop_tim;
        logic thru_tim;
    } t1m_cond_t;
    // Five counts: errored, severe, unavailable, slip, bursty.
    typedef logic [4:0][`T1M_CW-1:0] t1m_cnt_t;
    typedef logic [4:0][`T1M_TW-1:0] t1m_tot_t;
    // Slot masks; entry 0 is the other T1, 1.. the data ports.
    typedef logic [`T1M_NPORT:0][`T1M_NSLOT-1:0] t1m_map_t;
    // Drop/insert slot number (1..24) per network slot, 0 none.
    typedef logic [`T1M_NSLOT-1:0][4:0] t1m_pair_t;
    // Whole state of the block.
    typedef struct packed {
        t1m_tx_t tx;
        logic [6:0] code_cnt;
        logic code_err;
        logic [31:0] tenth;
        logic [3:0] sub;
        logic [9:0] isec;
        logic [3:0][4:0] red;
        logic [4:0] flg;
        t1m_cnt_t cur;
        logic [`T1M_NINTV-1:0][4:0][`T1M_CW-1:0] hist;
        logic [6:0] wptr;
        logic [6:0] nvalid;
        t1m_tot_t tot;
        t1m_cnt_t rd;
        logic [`T1M_AL_W-1:0] net_al;
        logic [`T1M_AL_W-1:0] di_al;
        logic [1:0] net_lb;
        logic [1:0] di_lb;
        logic [1:0] net_sm;
        logic [1:0] di_sm;
        logic [1:0] net_cs;
        logic [1:0] di_cs;
        logic [3:0] net_fdl;
        t1m_map_t map_net;
        t1m_map_t map_di;
        t1m_pair_t pair;
        logic map_ok;
        logic map_err;
    } t1m_state_t;
endpackage

// *** rtl/t1m_maint.sv ***
/*
 * T1 maintenance logic: test code timing, alarm and line status,
 * error-second counters with history, channel map checking.
 * Assumes all inputs come from logic on sys_clk.
 */
`timescale 1ns/100ps
`include "t1m_defs.svh"
module t1m_maint
    import t1m_pkg::*;
#(
    parameter int TENTH_CYC = `T1M_CLK_HZ / 1000 * `T1M_TENTH_MS
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Send code requests.
    input wire logic net_code_wr,
    input wire logic [3:0] net_code_val,
    input wire logic di_code_wr,
    input wire logic [3:0] di_code_val,
    output t1m_tx_t tx_pattern,
    output logic code_err,
    output logic [3:0] net_send_code_select,
    output logic [3:0] di_send_code_select,
    // Line conditions and options.
    input wire t1m_cond_t net_cond,
    input wire t1m_cond_t di_cond,
    input wire logic [`T1M_NSLOT-1:0] net_rbs,
    input wire logic [`T1M_NSLOT-1:0] di_rbs,
    input wire logic prm_enable,
    input wire logic carrier_fdl_enable,
    // Status words.
    output logic [`T1M_AL_W-1:0] net_line_alarm_status,
    output logic [`T1M_AL_W-1:0] di_line_alarm_status,
    output logic [1:0] net_loopback_state,
    output logic [1:0] di_loopback_state,
    output logic [1:0] net_signaling_mode,
    output logic [1:0] di_signaling_mode,
    output logic [1:0] net_transmit_clock_source,
    output logic [1:0] di_transmit_clock_source,
    output logic [3:0] net_data_link_usage,
    output logic [3:0] di_data_link_usage,
    // Error seconds.
    input wire logic [4:0] err_evt,
    input wire logic [6:0] history_interval_number,
    output t1m_cnt_t cur_counts,
    output t1m_cnt_t hist_counts,
    output t1m_tot_t total_counts,
    output logic [6:0] valid_intervals,
    // Time slot map.
    input wire logic map_wr,
    input wire t1m_map_t map_net,
    input wire t1m_map_t map_di,
    output logic map_ok,
    output logic map_err,
    output t1m_map_t time_slot_map_net,
    output t1m_map_t time_slot_map_di,
    output t1m_pair_t slot_pair
);
    // Derived counts in tenths of a second and seconds.
    localparam int CODE_T = `T1M_CODE_S * 1000 / `T1M_TENTH_MS;
    localparam int RED_T = `T1M_RED_MS / `T1M_TENTH_MS;
    localparam int TPS = 1000 / `T1M_TENTH_MS;
    localparam int ISEC = `T1M_INTV_MIN * 60;

    // Present and next state.
    t1m_state_t q;
    t1m_state_t d;

    // Alarm word of one interface.
    function automatic logic [`T1M_AL_W-1:0] alarm(t1m_cond_t c, logic lof, logic los, logic net);
        logic [`T1M_AL_W-1:0] a;
        a = '0;
        a[`T1M_AL_YEL] = c.yellow;
        a[`T1M_AL_AIS] = c.ais;
        a[`T1M_AL_LOF] = lof;
        a[`T1M_AL_LOS] = los;
        a[`T1M_AL_LBK] = c.pay_loop | c.line_loop;
        a[`T1M_AL_OTH] = net & c.excessive_error_rate;
        a[`T1M_AL_NONE] = (a == '0);
        return a;
    endfunction

    // Persistence counter: runs while the condition holds, saturates.
    function automatic logic [4:0] red_nx(logic cond, logic [4:0] cnt, logic tick);
        if (!cond)
        begin
            return '0;
        end
        if (tick && cnt <= 5'(RED_T))
        begin
            return cnt + 5'h1;
        end
        return cnt;
    endfunction

    // Loopback state value; line loop takes precedence.
    function automatic logic [1:0] lbk(t1m_cond_t c);
        if (c.line_loop)
        begin
            return `T1M_LB_LINE;
        end
        return c.pay_loop ? `T1M_LB_PAY : `T1M_LB_NONE;
    endfunction

    // Transmit clock source value.
    function automatic logic [1:0] clks(t1m_cond_t c);
        if (c.loop_tim)
        begin
            return `T1M_CS_LOOP;
        end
        return c.thru_tim ? `T1M_CS_THRU : `T1M_CS_LOCAL;
    endfunction

    // Number of set slots in a mask.
    function automatic logic [4:0] pop(logic [`T1M_NSLOT-1:0] m);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < `T1M_NSLOT; i++)
        begin
            n = n + 5'(m[i]);
        end
        return n;
    endfunction

    // True when two entries of one map claim the same slot.
    function automatic logic ovl(t1m_map_t m);
        logic [`T1M_NSLOT-1:0] seen;
        logic bad;
        seen = '0;
        bad = 1'b0;
        for (int p = 0; p <= `T1M_NPORT; p++)
        begin
            bad = bad | (|(seen & m[p]));
            seen = seen | m[p];
        end
        return bad;
    endfunction

    // Next-state logic of the whole block.
    always_comb
    begin
        logic tick;
        logic sec;
        logic bad;
        logic [4:0] flg;
        logic [7:0] hi;
        t1m_cnt_t nxt;
        logic [`T1M_NSLOT-1:0][4:0] dsl;
        int k;
        tick = 1'b0;
        sec = 1'b0;
        bad = 1'b0;
        flg = '0;
        hi = '0;
        nxt = '0;
        dsl = '0;
        k = 0;
        d = q;
        // Tenth-second and second enables.
        tick = (q.tenth == 32'(TENTH_CYC - 1));
        d.tenth = tick ? '0 : q.tenth + 32'h1;
        sec = tick && (q.sub == 4'(TPS - 1));
        if (tick)
        begin
            d.sub = sec ? '0 : q.sub + 4'h1;
        end
        // Timed codes end after a full ten seconds of ticks.
        d.code_err = 1'b0;
        case (q.tx)
            T1M_TX_UP, T1M_TX_DN:
            begin
                if (tick && q.code_cnt == 7'(CODE_T))
                begin
                    d.tx = T1M_TX_IDLE;
                end
                else if (tick)
                begin
                    d.code_cnt = q.code_cnt + 7'h1;
                end
            end
            default:
            begin
                d.code_cnt = q.code_cnt;
            end
        endcase
        // A new request restarts the timer; unknown codes are refused.
        if (net_code_wr)
        begin
            case (net_code_val)
                `T1M_SC_NONE: d.tx = T1M_TX_IDLE;
                `T1M_SC_UP: d.tx = T1M_TX_UP;
                `T1M_SC_DN: d.tx = T1M_TX_DN;
                `T1M_SC_QRSS: d.tx = T1M_TX_QRSS;
                `T1M_SC_OTH: d.tx = T1M_TX_OTH;
                default: d.code_err = 1'b1;
            endcase
            // A refused code leaves a running timer alone, so a timed code still lasts its full time.
            if (!d.code_err)
            begin
                d.code_cnt = '0;
            end
        end
        // The drop/insert side takes only the no-code value.
        if (di_code_wr && di_code_val != `T1M_SC_NONE)
        begin
            d.code_err = 1'b1;
        end
        // Red alarm persistence, network then drop/insert.
        d.red[0] = red_nx(net_cond.oof, q.red[0], tick);
        d.red[1] = red_nx(net_cond.los, q.red[1], tick);
        d.red[2] = red_nx(di_cond.oof, q.red[2], tick);
        d.red[3] = red_nx(di_cond.los, q.red[3], tick);
        // Status words.
        d.net_al = alarm(net_cond, q.red[0] > 5'(RED_T), q.red[1] > 5'(RED_T), 1'b1);
        d.di_al = alarm(di_cond, q.red[2] > 5'(RED_T), q.red[3] > 5'(RED_T), 1'b0);
        d.net_lb = lbk(net_cond);
        d.di_lb = lbk(di_cond);
        d.net_sm = (|net_rbs) ? `T1M_SM_RBS : `T1M_SM_NONE;
        d.di_sm = (|di_rbs) ? `T1M_SM_RBS : `T1M_SM_NONE;
        d.net_cs = clks(net_cond);
        d.di_cs = clks(di_cond);
        d.net_fdl = (prm_enable ? `T1M_FDL_PRM : 4'h0) | (carrier_fdl_enable ? `T1M_FDL_CARR : 4'h0);
        if (d.net_fdl == 4'h0)
        begin
            d.net_fdl = `T1M_FDL_NONE;
        end
        // Error events mark the second; an event on the tick still counts.
        flg = q.flg | err_evt;
        d.flg = sec ? '0 : flg;
        if (sec)
        begin
            for (int i = 0; i < 5; i++)
            begin
                nxt[i] = q.cur[i] + `T1M_CW'(flg[i]);
            end
            if (q.isec == 10'(ISEC - 1))
            begin
                // Interval boundary: newest slot is interval 1.
                d.isec = '0;
                d.cur = '0;
                d.hist[q.wptr] = nxt;
                d.wptr = (q.wptr == 7'(`T1M_NINTV - 1)) ? '0 : q.wptr + 7'h1;
                if (q.nvalid != 7'(`T1M_NINTV))
                begin
                    d.nvalid = q.nvalid + 7'h1;
                end
                // Add the finished interval, drop the one that ages out.
                for (int i = 0; i < 5; i++)
                begin
                    d.tot[i] = q.tot[i] + `T1M_TW'(nxt[i]);
                    if (q.nvalid == 7'(`T1M_NINTV))
                    begin
                        d.tot[i] = d.tot[i] - `T1M_TW'(q.hist[q.wptr][i]);
                    end
                end
            end
            else
            begin
                d.isec = q.isec + 10'h1;
                d.cur = nxt;
            end
        end
        // History read: interval n sits n places behind the write slot.
        hi = {1'b0, q.wptr} + 8'(`T1M_NINTV) - {1'b0, history_interval_number};
        if (hi >= 8'(`T1M_NINTV))
        begin
            hi = hi - 8'(`T1M_NINTV);
        end
        d.rd = '0;
        if (history_interval_number != '0 && history_interval_number <= q.nvalid)
        begin
            d.rd = q.hist[hi[6:0]];
        end
        // Channel map check and apply.
        d.map_ok = 1'b0;
        d.map_err = 1'b0;
        if (map_wr)
        begin
            bad = ovl(map_net) | ovl(map_di);
            bad = bad | (pop(map_net[0]) != pop(map_di[0]));
            for (int p = 1; p <= `T1M_NPORT; p++)
            begin
                bad = bad | ((|map_net[p]) & (|map_di[p]));
            end
            if (bad)
            begin
                d.map_err = 1'b1;
            end
            else
            begin
                d.map_ok = 1'b1;
                d.map_net = map_net;
                d.map_di = map_di;
                // Rank the drop/insert slots, then pair by rank.
                for (int s = 0; s < `T1M_NSLOT; s++)
                begin
                    if (map_di[0][s])
                    begin
                        dsl[k] = 5'(s + 1);
                        k = k + 1;
                    end
                end
                k = 0;
                for (int s = 0; s < `T1M_NSLOT; s++)
                begin
                    d.pair[s] = '0;
                    if (map_net[0][s])
                    begin
                        d.pair[s] = dsl[k];
                        k = k + 1;
                    end
                end
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs.
    assign tx_pattern = q.tx;
    assign code_err = q.code_err;
    assign net_send_code_select = (q.tx == T1M_TX_UP) ? `T1M_SC_UP : (q.tx == T1M_TX_DN) ? `T1M_SC_DN :
        (q.tx == T1M_TX_QRSS) ? `T1M_SC_QRSS : (q.tx == T1M_TX_OTH) ? `T1M_SC_OTH : `T1M_SC_NONE;
    assign di_send_code_select = `T1M_SC_NONE;
    assign net_line_alarm_status = q.net_al;
    assign di_line_alarm_status = q.di_al;
    assign net_loopback_state = q.net_lb;
    assign di_loopback_state = q.di_lb;
    assign net_signaling_mode = q.net_sm;
    assign di_signaling_mode = q.di_sm;
    assign net_transmit_clock_source = q.net_cs;
    assign di_transmit_clock_source = q.di_cs;
    assign net_data_link_usage = q.net_fdl;
    assign di_data_link_usage = `T1M_FDL_NONE;
    assign cur_counts = q.cur;
    assign hist_counts = q.rd;
    assign total_counts = q.tot;
    assign valid_intervals = q.nvalid;
    assign map_ok = q.map_ok;
    assign map_err = q.map_err;
    assign time_slot_map_net = q.map_net;
    assign time_slot_map_di = q.map_di;
    assign slot_pair = q.pair;

    // No-code write stops any pattern.
    property p_code_none;
        @(posedge sys_clk) disable iff (!rst_n)
        net_code_wr && net_code_val == `T1M_SC_NONE |=> tx_pattern == T1M_TX_IDLE;
    endproperty
    a_code_none: assert property (p_code_none) else $error("no-code did not stop pattern");

    // Loop-up code starts at once with its tick count cleared.
    property p_code_up;
        @(posedge sys_clk) disable iff (!rst_n)
        net_code_wr && net_code_val == `T1M_SC_UP |=> tx_pattern == T1M_TX_UP && q.code_cnt == 7'h0;
    endproperty
    a_code_up: assert property (p_code_up) else $error("loop-up code not started");

    // Timed codes end on the tick after the full count.
    property p_code_end;
        @(posedge sys_clk) disable iff (!rst_n)
        (q.tx == T1M_TX_DN || q.tx == T1M_TX_UP) && q.code_cnt == 7'(CODE_T) && q.tenth == 32'(TENTH_CYC - 1)
            && !net_code_wr |=> tx_pattern == T1M_TX_IDLE;
    endproperty
    a_code_end: assert property (p_code_end) else $error("timed code did not end");

    // QRSS holds without a new request.
    property p_qrss_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        tx_pattern == T1M_TX_QRSS && !net_code_wr |=> tx_pattern == T1M_TX_QRSS;
    endproperty
    a_qrss_hold: assert property (p_qrss_hold) else $error("QRSS ended on its own");

    // 1-in-8 starts and holds.
    property p_oth_start;
        @(posedge sys_clk) disable iff (!rst_n)
        net_code_wr && net_code_val == `T1M_SC_OTH ##1 !net_code_wr |-> tx_pattern == T1M_TX_OTH ##1 tx_pattern == T1M_TX_OTH;
    endproperty
    a_oth_start: assert property (p_oth_start) else $error("1-in-8 not held");

    // Drop/insert side refuses test codes.
    property p_di_refuse;
        @(posedge sys_clk) disable iff (!rst_n)
        di_code_wr && di_code_val != `T1M_SC_NONE |=> code_err && di_send_code_select == `T1M_SC_NONE;
    endproperty
    a_di_refuse: assert property (p_di_refuse) else $error("drop/insert code not refused");

    // Loss of frame only after the persistence count.
    property p_lof;
        @(posedge sys_clk) disable iff (!rst_n)
        net_line_alarm_status[`T1M_AL_LOF] |-> $past(q.red[0]) > 5'(RED_T);
    endproperty
    a_lof: assert property (p_lof) else $error("loss of frame too early");

    // Loss of signal clears two cycles after the condition goes.
    property p_los;
        @(posedge sys_clk) disable iff (!rst_n)
        !net_cond.los |-> ##2 !net_line_alarm_status[`T1M_AL_LOS];
    endproperty
    a_los: assert property (p_los) else $error("loss of signal stuck");

    // Robbed bit use is reported on the next cycle.
    property p_rbs;
        @(posedge sys_clk) disable iff (!rst_n)
        |net_rbs |=> net_signaling_mode == `T1M_SM_RBS;
    endproperty
    a_rbs: assert property (p_rbs) else $error("robbed bit not reported");

    // A port on both T1 maps is rejected and leaves the map alone.
    property p_map_bad;
        @(posedge sys_clk) disable iff (!rst_n)
        map_wr && (|map_net[1]) && (|map_di[1]) |=> map_err && !map_ok && time_slot_map_net == $past(q.map_net);
    endproperty
    a_map_bad: assert property (p_map_bad) else $error("invalid map accepted");
endmodule // t1m_maint

// *** verif/t1m_net_model.sv ***
/*
 * Far-end T1 network model: reports line conditions and error events.
 * Assumes the bench asks for conditions on the rising edge of sys_clk.
 */
`timescale 1ns/100ps
module t1m_net_model
    import t1m_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Requests from the bench.
    input wire t1m_cond_t want,
    input wire logic [4:0] hit,
    // Toward the block.
    output t1m_cond_t cond,
    output logic [4:0] err_evt
);
    // Conditions show one clock late, as a framer reports them.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cond <= '0;
            err_evt <= 5'h0;
        end
        else
        begin
            cond <= want;
            // A one-cycle request gives a one-cycle event.
            err_evt <= hit;
        end
    end
endmodule // t1m_net_model

// *** verif/t1_line_test_and_alarm_status_tb.sv ***
/*
 * Self-checking bench of the T1 maintenance block.
 * Assumes a short tenth-second tick (TENTH_CYC of 4) to keep runs brief.
 */
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((e) !== (a)) begin miscompares++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module t1_line_test_and_alarm_status_tb
    import t1m_pkg::*;
;
    // Inputs; those the bench drives are given a value at time zero, net_cond and err_evt come from the model.
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic net_code_wr = 1'b0, di_code_wr = 1'b0, map_wr = 1'b0;
    logic [3:0] net_code_val = 4'h1, di_code_val = 4'h1;
    t1m_cond_t want = '0, di_cond = '0, net_cond;
    logic [4:0] hit = 5'h0, err_evt;
    logic [23:0] net_rbs = 24'h0, di_rbs = 24'h0;
    logic prm_enable = 1'b0, carrier_fdl_enable = 1'b0;
    logic [6:0] hnum = 7'h1, valid_intervals;
    t1m_map_t map_net = '0, map_di = '0;
    // Outputs.
    logic code_err, map_ok, map_err;
    logic [3:0] nsel, dsel, nfdl, dfdl;
    logic [12:0] nal, dal;
    logic [1:0] nlb, terminal_side_loopback, nsm, dsm, ncs, dcs;
    t1m_cnt_t cur_counts, hist_counts;
    t1m_tot_t total_counts;
    t1m_pair_t slot_pair;
    t1m_map_t tsn, tsd;
    // Expected notes waiting for the watcher.
    typedef struct { int sel; logic [127:0] exp; } t1m_note_t;
    t1m_note_t notes[$];
    event look;
    int miscompares = 0;
    int checked = 0;
    string names[15] = '{"select", "code_err", "net_alarm", "di_alarm", "modes", "link_usage",
        "map_result", "slot_pair", "current", "history", "total", "valid", "red_bits", "net_map", "di_map"};
    logic [8:0] sc[7] = '{9'h040, 9'h020, 9'h010, 9'h008, 9'h00c, 9'h002, 9'h001};
    logic [12:0] ea[7] = '{13'h2, 13'h8, 13'h1000, 13'h80, 13'h80, 13'h1, 13'h1};
    logic [11:0] em[7] = '{12'h59a, 12'h59a, 12'h59a, 12'h99a, 12'hd9a, 12'h596, 12'h59e};
    logic [3:0] codes[5] = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h1};

    t1m_net_model u_net (.sys_clk, .rst_n, .want, .hit, .cond(net_cond), .err_evt);
    t1m_maint #(.TENTH_CYC(4)) DUT (
        .sys_clk, .rst_n, .net_code_wr, .net_code_val, .di_code_wr, .di_code_val, .tx_pattern(),
        .code_err, .net_send_code_select(nsel), .di_send_code_select(dsel), .net_cond, .di_cond,
        .net_rbs, .di_rbs, .prm_enable, .carrier_fdl_enable, .net_line_alarm_status(nal),
        .di_line_alarm_status(dal), .net_loopback_state(nlb), .di_loopback_state(terminal_side_loopback),
        .net_signaling_mode(nsm), .di_signaling_mode(dsm), .net_transmit_clock_source(ncs),
        .di_transmit_clock_source(dcs), .net_data_link_usage(nfdl), .di_data_link_usage(dfdl),
        .err_evt, .history_interval_number(hnum), .cur_counts, .hist_counts, .total_counts,
        .valid_intervals, .map_wr, .map_net, .map_di, .map_ok, .map_err,
        .time_slot_map_net(tsn), .time_slot_map_di(tsd), .slot_pair);

    // Picks the output group that a note refers to.
    function automatic logic [127:0] get(input int sel);
        case (sel)
            0: return 128'({dsel, nsel});
            1: return 128'(code_err);
            2: return 128'(nal);
            3: return 128'(dal);
            4: return 128'({nlb, terminal_side_loopback, nsm, dsm, ncs, dcs});
            5: return 128'({nfdl, dfdl});
            6: return 128'({map_ok, map_err});
            7: return 128'(slot_pair);
            8: return 128'(cur_counts);
            9: return 128'(hist_counts);
            10: return 128'(total_counts);
            11: return 128'(valid_intervals);
            13: return 128'(tsn);
            14: return 128'(tsd);
            default: return 128'({nal[5], nal[6]});
        endcase
    endfunction

    task automatic note(input int sel, input logic [127:0] v);
        notes.push_back('{sel, v});
        ->look;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Writes one send code for either side as a single-cycle strobe.
    task automatic code(input logic di, input logic [3:0] v);
        @(posedge sys_clk);
        net_code_wr <= !di;
        di_code_wr <= di;
        net_code_val <= v;
        di_code_val <= v;
        @(posedge sys_clk);
        net_code_wr <= 1'b0;
        di_code_wr <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic send_map(input t1m_map_t n, input t1m_map_t d);
        @(posedge sys_clk);
        map_net <= n;
        map_di <= d;
        map_wr <= 1'b1;
        @(posedge sys_clk);
        map_wr <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Clock of 25 ns.
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Watcher: compares the oldest notes whenever results are ready.
    initial
    begin
        t1m_note_t n;
        forever
        begin
            @(look);
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                `CHK(names[n.sel], n.exp, get(n.sel))
            end
        end
    end

    // Watchdog well beyond the full interval wait.
    initial
    begin
        #(25 * 60000);
        miscompares++;
        stop_test();
    end

    // Main sequence.
    initial
    begin
        t1m_map_t mn, md, kd;
        t1m_pair_t ep;
        void'($urandom(32'h89cad413));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(2);
        note(0, 8'h11);
        note(2, 13'h1);
        note(4, 12'h55a);
        note(5, 8'h88);
        $display("test reset done");
        foreach (codes[i])
        begin
            code(1'b0, codes[i]);
            note(0, {4'h1, codes[i]});
        end
        code(1'b0, 4'h5);
        code(1'b0, 4'h3);
        note(1, 1);
        code(1'b1, 4'h2);
        note(1, 1);
        note(0, 8'h15);
        code(1'b0, 4'h2);
        settle(400);
        note(0, 8'h12);
        settle(12);
        note(0, 8'h11);
        $display("test codes done");
        @(posedge sys_clk);
        net_rbs <= 24'($urandom) | 24'h1;
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk);
            want <= t1m_cond_t'(sc[i]);
            settle(3);
            note(2, ea[i]);
            note(4, em[i]);
        end
        @(posedge sys_clk);
        want <= '0;
        di_cond <= t1m_cond_t'(9'h054);
        di_rbs <= 24'h800000;
        prm_enable <= 1'b1;
        settle(3);
        note(3, 13'h82);
        note(4, 12'h7aa);
        note(5, 8'h28);
        @(posedge sys_clk);
        carrier_fdl_enable <= 1'b1;
        settle(2);
        note(5, 8'h68);
        $display("test status done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge sys_clk);
            want <= t1m_cond_t'(k ? 9'h080 : 9'h100);
            settle(100);
            note(12, 0);
            settle(20);
            note(12, k ? 2'b01 : 2'b10);
            @(posedge sys_clk);
            want <= '0;
            settle(4);
            note(2, 13'h1);
        end
        $display("test red alarms done");
        @(posedge sys_clk);
        hit <= 5'h1f;
        @(posedge sys_clk);
        hit <= 5'h0;
        settle(48);
        note(8, {5{10'h1}});
        for (int i = 0; i < 40000 && valid_intervals !== 7'h1; i++)
            @(posedge sys_clk);
        settle(2);
        note(11, 1);
        note(9, {5{10'h1}});
        note(10, {5{17'h1}});
        note(8, 0);
        @(posedge sys_clk);
        hnum <= 7'h2;
        settle(2);
        note(9, 0);
        $display("test error seconds done");
        mn = '0;
        md = '0;
        mn[0] = 24'h15;
        md[0] = 24'h4600;
        mn[1] = 24'h1 << (5 + $urandom % 19);
        ep = '0;
        ep[0] = 5'd10;
        ep[2] = 5'd11;
        ep[4] = 5'd15;
        send_map(mn, md);
        note(6, 2'b10);
        note(7, ep);
        note(13, mn);
        note(14, md);
        kd = md;
        mn[2] = 24'h1;
        send_map(mn, md);
        note(6, 2'b01);
        mn[2] = '0;
        md[0] = 24'h600;
        send_map(mn, md);
        note(6, 2'b01);
        note(7, ep);
        md[0] = 24'h4600;
        md[1] = 24'h1;
        send_map(mn, md);
        note(6, 2'b01);
        note(13, mn);
        note(14, kd);
        $display("test maps done");
        @(posedge sys_clk);
        stop_test();
    end
endmodule // t1_line_test_and_alarm_status_tb
